// [pkg/oven_panel_pkg.sv]
// Constants and timing figures for the oven front-panel controller
// Operation
// R1: Toggle button flips active/standby; LED shows it
// R2: Active regulates; standby heater off, fan held
// R3: Power-up enters standby with fan stopped
// R4: Source button flips local/remote; LED shows it
// R5: Local accepts panel, ignores host commands
// R6: Local also accepts TTL; latest command wins
// R7: Remote obeys host; panel ignored but source
// R8: Arrow press steps one degree; hold repeats
// R9: Measured display rounds at half degree
// R10: Set point 0..41, or 0..80 with switch one
// R11: Code display shows letter plus identifier
// R12: Error keeps running, short tone unless switch three
// R13: Fault shuts down, red lamp, long tone
// R14: Code clears after condition gone, door cycled
// R15: Door open stops heater and fan
// R16: Fault lamp follows shown fault code
// R17: Arrow steps saturate at range limits
// R18: Presses debounced, edge detected, one action each
package oven_panel_pkg;
   // ------------------------------------------------------------
   // Clock and time figures
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   localparam int unsigned DEBOUNCE_MS   = 10;
   localparam int unsigned REP_DELAY_MS  = 500;
   localparam int unsigned REP_PERIOD_MS = 150;
   localparam int unsigned SHORT_TONE_MS = 100;
   localparam int unsigned LONG_TONE_MS  = 1000;
   localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CYC_PER_MS;
   localparam int unsigned REP_DELAY_CYC = REP_DELAY_MS * CYC_PER_MS;
   localparam int unsigned REP_PERIOD_CYC = REP_PERIOD_MS * CYC_PER_MS;
   localparam int unsigned SHORT_TONE_CYC = SHORT_TONE_MS * CYC_PER_MS;
   localparam int unsigned LONG_TONE_CYC = LONG_TONE_MS * CYC_PER_MS;
   // ------------------------------------------------------------
   // Set point and display figures
   // ------------------------------------------------------------
   localparam int unsigned SP_W          = 7;
   localparam logic [6:0]  SP_MIN        = 7'h00;
   localparam logic [6:0]  SP_MAX_LOW    = 7'h29;  // 41 degrees
   localparam logic [6:0]  SP_MAX_HIGH   = 7'h50;  // 80 degrees
   localparam logic [6:0]  SP_RESET      = 7'h00;
   localparam int unsigned TEMP_FRAC     = 4;      // Sixteenths of a degree
   localparam logic [11:0] TEMP_HALF     = 12'h008;
   localparam logic [7:0]  FAN_RESET     = 8'h00;
   localparam logic        CODE_ERROR    = 1'b0;
   localparam logic        CODE_FAULT    = 1'b1;
endpackage : oven_panel_pkg

// [core/button_conditioner.sv]
// Debounce, press-edge detection and hold auto-repeat for one button
`timescale 1ns/1ps
module button_conditioner #(
   parameter int unsigned DEB_CYC  = oven_panel_pkg::DEBOUNCE_CYC,
   parameter int unsigned DLY_CYC  = oven_panel_pkg::REP_DELAY_CYC,
   parameter int unsigned PER_CYC  = oven_panel_pkg::REP_PERIOD_CYC,
   parameter bit          REPEAT   = 1'b0
)(
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic raw,
   output logic      press
);
   initial
   begin
      if (DEB_CYC < 1 || DLY_CYC < 2 || PER_CYC < 2)
         $error("button_conditioner: counts too small");
   end

   typedef enum logic {REL, HELD} deb_e;
   typedef struct packed {
      deb_e        st;
      logic [31:0] deb;
      logic [31:0] rep;
      logic        press;
   } btn_s;

   btn_s cur;
   btn_s next_cur;

   // ------------------------------------------------------------
   // Stable-level filter and press generation
   // ------------------------------------------------------------
   // Bounce on either edge restarts the filter, so one press is one pulse
   always_comb
   begin
      next_cur       = cur;
      next_cur.press = 1'b0;
      if (raw != (cur.st == HELD))
      begin
         if (cur.deb >= DEB_CYC - 1)
         begin
            next_cur.deb = '0;
            unique case (cur.st)
               REL:
               begin
                  next_cur.st    = HELD;
                  next_cur.press = 1'b1;  // see R18
                  next_cur.rep   = DLY_CYC;
               end
               HELD:
               begin
                  next_cur.st = REL;
               end
            endcase
         end
         else
            next_cur.deb = cur.deb + 32'h1;
      end
      else
      begin
         next_cur.deb = '0;
         // Held arrow keeps stepping after the first delay
         if (REPEAT && cur.st == HELD)
         begin
            if (cur.rep <= 32'h1)
            begin
               next_cur.press = 1'b1;  // see R8
               next_cur.rep   = PER_CYC;
            end
            else
               next_cur.rep = cur.rep - 32'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cur <= '{st: REL, deb: 32'h0, rep: 32'h0, press: 1'b0};
      else
         cur <= next_cur;
   end

   assign press = cur.press;
endmodule : button_conditioner

// [core/oven_panel_ctrl.sv]
// Front-panel controller: modes, set point, displays, codes, tone, lamp
`timescale 1ns/1ps
module oven_panel_ctrl #(
   parameter int unsigned DEB_CYC   = oven_panel_pkg::DEBOUNCE_CYC,
   parameter int unsigned DLY_CYC   = oven_panel_pkg::REP_DELAY_CYC,
   parameter int unsigned PER_CYC   = oven_panel_pkg::REP_PERIOD_CYC,
   parameter int unsigned SHORT_CYC = oven_panel_pkg::SHORT_TONE_CYC,
   parameter int unsigned LONG_CYC  = oven_panel_pkg::LONG_TONE_CYC
)(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        btn_activity,
   input  wire logic        btn_source,
   input  wire logic        btn_up,
   input  wire logic        btn_down,
   input  wire logic        ttl_req,
   input  wire logic        ttl_active,
   input  wire logic        host_act_req,
   input  wire logic        host_active,
   input  wire logic        host_sp_req,
   input  wire logic [6:0]  host_sp,
   input  wire logic        cfg_range_high,
   input  wire logic        cfg_tone_off,
   input  wire logic        door_open,
   input  wire logic [11:0] temp_meas,
   input  wire logic        regulate_heat,
   input  wire logic [7:0]  regulate_fan,
   input  wire logic        error_cond,
   input  wire logic [3:0]  error_id,
   input  wire logic        fault_cond,
   input  wire logic [3:0]  fault_id,
   output logic             active_led,
   output logic             remote_led,
   output logic             heater_on,
   output logic [7:0]       fan_speed,
   output logic [6:0]       setpoint,
   output logic [7:0]       temp_display,
   output logic             code_show,
   output logic             fault_code_indication,
   output logic [3:0]       code_id,
   output logic             fault_lamp,
   output logic             tone
);
   initial
   begin
      if (SHORT_CYC < 1 || LONG_CYC <= SHORT_CYC)
         $error("oven_panel_ctrl: tone lengths invalid");
   end

   typedef struct packed {
      logic        active;
      logic        remote;
      logic        heater;
      logic [7:0]  fan;
      logic [7:0]  fan_hold;
      logic [6:0]  sp;
      logic [7:0]  tdisp;
      logic        show;
      logic        is_fault;
      logic [3:0]  id;
      logic        door_seen;
      logic        err_d;
      logic        flt_d;
      logic [31:0] tone_cnt;
      logic        tone;
   } panel_s;

   panel_s cur;
   panel_s next_cur;
   logic   p_act;
   logic   p_src;
   logic   p_up;
   logic   p_dn;

   // ------------------------------------------------------------
   // Button conditioning
   // ------------------------------------------------------------
   // Only the arrows repeat; a held toggle must not chatter the mode
   button_conditioner #(.DEB_CYC(DEB_CYC), .DLY_CYC(DLY_CYC), .PER_CYC(PER_CYC),
                        .REPEAT(1'b0))
      u_act (.mclk(mclk), .rst_b(rst_b), .raw(btn_activity), .press(p_act));
   button_conditioner #(.DEB_CYC(DEB_CYC), .DLY_CYC(DLY_CYC), .PER_CYC(PER_CYC),
                        .REPEAT(1'b0))
      u_src (.mclk(mclk), .rst_b(rst_b), .raw(btn_source), .press(p_src));
   button_conditioner #(.DEB_CYC(DEB_CYC), .DLY_CYC(DLY_CYC), .PER_CYC(PER_CYC),
                        .REPEAT(1'b1))
      u_up (.mclk(mclk), .rst_b(rst_b), .raw(btn_up), .press(p_up));
   button_conditioner #(.DEB_CYC(DEB_CYC), .DLY_CYC(DLY_CYC), .PER_CYC(PER_CYC),
                        .REPEAT(1'b1))
      u_dn (.mclk(mclk), .rst_b(rst_b), .raw(btn_down), .press(p_dn));

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   logic [6:0]  sp_max;
   logic        stop;
   logic [12:0] t_round;
   logic        err_rise;
   logic        flt_rise;
   logic        code_clear;

   always_comb
   begin
      next_cur = cur;
      sp_max   = cfg_range_high ? oven_panel_pkg::SP_MAX_HIGH
                                : oven_panel_pkg::SP_MAX_LOW;  // see R10
      err_rise = error_cond && !cur.err_d;
      flt_rise = fault_cond && !cur.flt_d;
      next_cur.err_d = error_cond;
      next_cur.flt_d = fault_cond;

      // Mode source toggles in both modes
      if (p_src)
         next_cur.remote = !cur.remote;  // see R4
      if (!cur.remote)  // see R5
      begin
         // Local: panel and TTL; TTL in the same cycle counts as later
         if (p_act)
            next_cur.active = !cur.active;  // see R1
         if (ttl_req)
            next_cur.active = ttl_active;  // see R6
         if (p_up && cur.sp < sp_max)
            next_cur.sp = cur.sp + 7'h01;  // see R8
         else if (p_dn && cur.sp > oven_panel_pkg::SP_MIN)
            next_cur.sp = cur.sp - 7'h01;  // see R17
      end
      else
      begin
         // Remote: host only, panel keys other than source are dead
         if (host_act_req)
            next_cur.active = host_active;  // see R7
         if (host_sp_req)
            next_cur.sp = (host_sp > sp_max) ? sp_max : host_sp;  // see R10
      end
      // Narrowing the range pulls a high set point down
      if (next_cur.sp > sp_max)
         next_cur.sp = sp_max;  // see R10

      // Rounded measured temperature, saturating at the display width
      t_round = {1'b0, temp_meas} + {1'b0, oven_panel_pkg::TEMP_HALF};  // see R9
      if (t_round[12])
         next_cur.tdisp = 8'hff;
      else
         next_cur.tdisp = t_round[11:4];

      // Code capture; a fault outranks an error already shown
      code_clear = cur.show && cur.door_seen && !door_open
                   && !error_cond && !fault_cond;  // see R14
      if (cur.show && door_open)
         next_cur.door_seen = 1'b1;
      if (code_clear)
      begin
         next_cur.show      = 1'b0;
         next_cur.is_fault  = oven_panel_pkg::CODE_ERROR;
         next_cur.door_seen = 1'b0;
      end
      // New events win over a clear in the same cycle
      if (flt_rise)
      begin
         next_cur.show      = 1'b1;  // see R11
         next_cur.is_fault  = oven_panel_pkg::CODE_FAULT;  // see R16
         next_cur.id        = fault_id;
         next_cur.door_seen = 1'b0;
         next_cur.tone_cnt  = LONG_CYC;  // see R13
      end
      else if (err_rise && !(cur.show && cur.is_fault))
      begin
         next_cur.show      = 1'b1;  // see R11
         next_cur.is_fault  = oven_panel_pkg::CODE_ERROR;
         next_cur.id        = error_id;
         next_cur.door_seen = 1'b0;
         if (!cfg_tone_off)
            next_cur.tone_cnt = SHORT_CYC;  // see R12
      end
      else if (cur.tone_cnt != 32'h0)
         next_cur.tone_cnt = cur.tone_cnt - 32'h1;
      next_cur.tone = (next_cur.tone_cnt != 32'h0);

      // Heater and fan: fault and open door stop both, standby holds fan
      stop = door_open || fault_cond || (cur.show && cur.is_fault);  // see R15
      next_cur.heater = cur.active && regulate_heat && !stop;  // see R2
      // A stop zeroes the fan, so the last active speed is kept apart
      if (stop)
         next_cur.fan = 8'h00;  // see R13
      else if (cur.active)
      begin
         next_cur.fan      = regulate_fan;
         next_cur.fan_hold = regulate_fan;
      end
      else
         next_cur.fan = cur.fan_hold;  // see R2
   end

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   // Power-up: standby, local, fan stopped
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cur <= '{active: 1'b0, remote: 1'b0, heater: 1'b0,
                  fan: oven_panel_pkg::FAN_RESET, sp: oven_panel_pkg::SP_RESET,
                  fan_hold: oven_panel_pkg::FAN_RESET,
                  tdisp: 8'h00, show: 1'b0, is_fault: 1'b0, id: 4'h0,
                  door_seen: 1'b0, err_d: 1'b0, flt_d: 1'b0,
                  tone_cnt: 32'h0, tone: 1'b0};  // see R3
      else
         cur <= next_cur;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign active_led            = cur.active;
   assign remote_led            = cur.remote;
   assign heater_on             = cur.heater;
   assign fan_speed             = cur.fan;
   assign setpoint              = cur.sp;
   assign temp_display          = cur.tdisp;
   assign code_show             = cur.show;
   assign fault_code_indication = cur.is_fault;
   assign code_id               = cur.id;
   assign fault_lamp            = cur.show && cur.is_fault;  // see R16
   assign tone                  = cur.tone;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // Door open now or already seen since the code appeared
   logic door_seen_any;
   assign door_seen_any = cur.door_seen || door_open;

   a_act_toggle: assert property (p_act && !cur.remote && !ttl_req && !p_src
      |=> active_led != $past(active_led))  // see R1
      else $error("activity press did not toggle");
   a_standby_heat: assert property (!active_led |=> !heater_on)  // see R2
      else $error("heater on in standby");
   a_src_toggle: assert property (p_src |=> remote_led != $past(remote_led))  // see R4
      else $error("source press did not toggle");
   a_remote_panel: assert property (cur.remote && !host_sp_req && !cfg_range_high
      && $stable(cfg_range_high) && (p_up || p_dn) |=> $stable(setpoint))  // see R7
      else $error("panel arrow acted in remote");
   a_up_step: assert property (p_up && !cur.remote && setpoint < sp_max
      && $stable(cfg_range_high) |=> setpoint == $past(setpoint) + 7'h01)  // see R8
      else $error("up step wrong");
   a_sp_range: assert property (##1 setpoint <= oven_panel_pkg::SP_MAX_HIGH
      && (cfg_range_high || $past(cfg_range_high)
          || setpoint <= oven_panel_pkg::SP_MAX_LOW))  // see R10
      else $error("set point out of range");
   a_temp_round: assert property (##1 temp_meas < 12'hff0
      |=> temp_display == 8'((13'($past(temp_meas)) + 13'h8) >> 4))  // see R9
      else $error("temperature rounding wrong");
   a_fault_stop: assert property (flt_rise |=> fault_lamp && tone ##1 !heater_on
      && fan_speed == 8'h00)  // see R13
      else $error("fault did not shut down");
   a_door_stop: assert property (door_open |=> !heater_on && fan_speed == 8'h00)  // see R15
      else $error("door open did not stop heater and fan");
   a_tone_mute: assert property (err_rise && cfg_tone_off && !cur.tone && !flt_rise
      |=> !tone)  // see R12
      else $error("muted error sounded tone");
   a_code_hold: assert property (code_show && !door_seen_any |=> code_show)  // see R14
      else $error("code cleared without door cycle");

   c_fault: cover property (flt_rise ##1 fault_lamp);
   c_clear: cover property (code_show && door_open ##[1:20] !code_show);
   c_remote_sp: cover property (cur.remote && host_sp_req);
   c_error_tone: cover property (err_rise ##1 tone);
endmodule : oven_panel_ctrl

// [tb/panel_operator.sv]
// Operator model: presses one panel button with contact bounce, then holds it
`timescale 1ns/1ps
module panel_operator (
   input  wire logic       mclk,
   input  wire logic [1:0] key,
   input  wire logic       push,
   input  wire logic [9:0] hold,
   output logic      [3:0] raw
);
   // -----------------------------------------------------------------
   // Press sequencer
   // -----------------------------------------------------------------
   int         cnt = 0;
   logic [1:0] held = 2'h0;

   // Count down the bounce plus the steady hold of the chosen key
   always @(posedge mclk)
   begin
      if (push)
      begin
         held <= key;
         cnt  <= int'(hold) + 3;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end

   // Contact chatters for three cycles, shorter than the filter span
   always_comb
   begin
      raw = 4'h0;
      if (cnt > int'(hold))
         raw[held] = cnt[0];
      else if (cnt > 0)
         raw[held] = 1'b1;
   end
endmodule : panel_operator

// [tb/test_oven_front_panel_controller.sv]
// Self-checking bench for the oven front-panel controller
`timescale 1ns/1ps
module test_oven_front_panel_controller;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   localparam int DEB = 4;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic [1:0]  key = 2'h0;
   logic        push = 1'b0;
   logic [9:0]  hold = 10'h000;
   logic [3:0]  raw;
   logic        ttl_req = 1'b0, ttl_active = 1'b0, host_act_req = 1'b0, host_active = 1'b0;
   logic        host_sp_req = 1'b0, cfg_range_high = 1'b0, cfg_tone_off = 1'b0;
   logic        door_open = 1'b0, regulate_heat = 1'b0, error_cond = 1'b0, fault_cond = 1'b0;
   logic [6:0]  host_sp = 7'h00;
   logic [11:0] temp_meas = 12'h000;
   logic [7:0]  regulate_fan = 8'h00;
   logic [3:0]  error_id = 4'h0, fault_id = 4'h0;
   logic        active_led, remote_led, heater_on, code_show, fault_code_indication;
   logic        fault_lamp, tone;
   logic [7:0]  fan_speed, temp_display;
   logic [6:0]  setpoint;
   logic [3:0]  code_id;
   int          failures = 0;
   int          comparisons = 0;

   // Free-running 200 MHz clock
   always #2.5 mclk = ~mclk;

   panel_operator op (.mclk(mclk), .key(key), .push(push), .hold(hold), .raw(raw));

   // Short counts keep the run brief; expectations follow these values
   oven_panel_ctrl #(.DEB_CYC(DEB), .DLY_CYC(20), .PER_CYC(8), .SHORT_CYC(10), .LONG_CYC(40))
   dut (.mclk(mclk), .rst_b(rst_b), .btn_activity(raw[0]), .btn_source(raw[1]),
      .btn_up(raw[2]), .btn_down(raw[3]), .ttl_req(ttl_req), .ttl_active(ttl_active),
      .host_act_req(host_act_req), .host_active(host_active), .host_sp_req(host_sp_req),
      .host_sp(host_sp), .cfg_range_high(cfg_range_high), .cfg_tone_off(cfg_tone_off),
      .door_open(door_open), .temp_meas(temp_meas), .regulate_heat(regulate_heat),
      .regulate_fan(regulate_fan), .error_cond(error_cond), .error_id(error_id),
      .fault_cond(fault_cond), .fault_id(fault_id), .active_led(active_led),
      .remote_led(remote_led), .heater_on(heater_on), .fan_speed(fan_speed),
      .setpoint(setpoint), .temp_display(temp_display), .code_show(code_show),
      .fault_code_indication(fault_code_indication), .code_id(code_id),
      .fault_lamp(fault_lamp), .tone(tone));

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Inputs always move 1 ns after the rising edge
   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   // Full press and release, with time for the release to settle too
   task tap(input logic [1:0] k, input logic [9:0] h);
      key = k;
      hold = h;
      push = 1'b1;
      cyc(1);
      push = 1'b0;
      cyc(int'(h) + DEB + 8);
   endtask : tap

   // One-cycle command pulse: 0 TTL input, 1 host state, 2 host set point
   task cmd(input int w, input logic v, input logic [6:0] sp);
      ttl_active = v;
      host_active = v;
      host_sp = sp;
      ttl_req = (w == 0);
      host_act_req = (w == 1);
      host_sp_req = (w == 2);
      cyc(1);
      {ttl_req, host_act_req, host_sp_req} = 3'h0;
      cyc(2);
   endtask : cmd

   // Full door open and close, checking heater and fan stop while open
   task door_cycle;
      door_open = 1'b1;
      cyc(3);
      chk(heater_on, 1'b0);
      chk(fan_speed, 8'h00);
      door_open = 1'b0;
      cyc(3);
   endtask : door_cycle

   task final_report;
      if (failures == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   // Watchdog sized well above the planned sequence
   initial
   begin
      repeat (20000) @(posedge mclk);
      failures++;
      final_report();
   end

   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   logic [11:0] tv [3] = '{12'h217, 12'h218, 12'hfff};
   logic [7:0]  te [3] = '{8'h21, 8'h22, 8'hff};

   initial
   begin
      regulate_heat = 1'b1;
      regulate_fan = 8'h5a;
      cyc(4);
      rst_b = 1'b1;
      cyc(1);
      chk({active_led, remote_led, heater_on, code_show, fault_lamp, tone}, 8'h00);
      chk(fan_speed, 8'h00);
      tap(2'h0, 10'd8);
      chk(active_led, 1'b1);
      chk({heater_on, fan_speed}, 9'h15a);
      tap(2'h0, 10'd8);
      chk(active_led, 1'b0);
      regulate_fan = 8'h33;
      cyc(3);
      chk({heater_on, fan_speed}, 9'h05a);
      // Standby speed comes back after the door closes
      door_cycle();
      chk(fan_speed, 8'h5a);
      cmd(0, 1'b1, 7'h00);
      chk(active_led, 1'b1);
      chk(fan_speed, 8'h33);
      tap(2'h0, 10'd8);
      chk(active_led, 1'b0);
      cmd(0, 1'b1, 7'h00);
      chk(active_led, 1'b1);
      cmd(1, 1'b0, 7'h00);
      cmd(2, 1'b0, 7'h14);
      chk({active_led, setpoint}, 8'h80);
      // Single taps move one degree; the bottom end holds
      tap(2'h2, 10'd8);
      tap(2'h2, 10'd8);
      chk(setpoint, 7'h02);
      for (int i = 0; i < 3; i++)
         tap(2'h3, 10'd8);
      chk(setpoint, 7'h00);
      tap(2'h2, 10'd600);
      chk(setpoint, 7'h29);
      cfg_range_high = 1'b1;
      tap(2'h2, 10'd600);
      chk(setpoint, 7'h50);
      cfg_range_high = 1'b0;
      cyc(3);
      chk(setpoint, 7'h29);
      for (int i = 0; i < 3; i++)
      begin
         temp_meas = tv[i];
         cyc(3);
         chk(temp_display, te[i]);
      end
      // Remote: only the source key acts, host rules
      tap(2'h1, 10'd8);
      chk(remote_led, 1'b1);
      tap(2'h0, 10'd8);
      tap(2'h3, 10'd8);
      chk({active_led, setpoint}, 8'ha9);
      cmd(2, 1'b0, 7'h7f);
      chk(setpoint, 7'h29);
      cmd(2, 1'b0, 7'h14);
      chk(setpoint, 7'h14);
      cmd(1, 1'b0, 7'h00);
      chk(active_led, 1'b0);
      cmd(1, 1'b1, 7'h00);
      chk(active_led, 1'b1);
      tap(2'h1, 10'd8);
      chk(remote_led, 1'b0);
      // Error: keeps running, short tone, code until door cycled
      error_id = 4'h3;
      error_cond = 1'b1;
      cyc(3);
      chk({code_show, fault_code_indication, code_id}, 8'h23);
      chk({tone, active_led, heater_on, fault_lamp}, 8'h0e);
      cyc(15);
      chk(tone, 1'b0);
      error_cond = 1'b0;
      cyc(3);
      chk(code_show, 1'b1);
      door_cycle();
      chk({code_show, heater_on}, 8'h01);
      cfg_tone_off = 1'b1;
      error_cond = 1'b1;
      cyc(3);
      chk({code_show, tone}, 8'h02);
      error_cond = 1'b0;
      door_cycle();
      // Fault: shutdown, lamp, long tone that the switch cannot mute
      fault_id = 4'h2;
      fault_cond = 1'b1;
      cyc(3);
      chk({code_show, fault_code_indication, code_id}, 8'h32);
      chk({fault_lamp, heater_on, fan_speed}, 10'h200);
      chk(tone, 1'b1);
      cyc(25);
      chk(tone, 1'b1);
      cyc(20);
      chk(tone, 1'b0);
      fault_cond = 1'b0;
      cyc(3);
      chk(fault_lamp, 1'b1);
      door_cycle();
      chk({code_show, fault_lamp}, 8'h00);
      final_report();
   end
endmodule : test_oven_front_panel_controller
